// file: common/aslt_pkg.sv
/*
 * Shared constants, types and helper functions for the serial link
 * latency and timing block: multiframe counts, wake-up times, datapath
 * latencies, trigger-to-start-code tables and lane character layout.
 * Assumes one sample clock of 40 MHz drives the whole block.
 */
// Summary of operation
// - In the third speed mode the RF decimator is always switched in.
// - In the fourth speed mode the RF decimator is always switched in.
// - After a falling sync request the lanes wait four multiframes before the first comma.
// - Comma characters are sent for at least one multiframe during code group sync.
// - Each lane carries twenty times converters over lanes bits per sample cycle.
// - Datapath latency is 16 cycles, plus 11 with the RF decimator, plus 100 with the HPF.
// - Trigger to start code takes 31/42/30/36 cycles on four lanes, 31/33/30/30 on two.
// - Wake-up takes 2 us from standby, 375 us device and 250 us link from power-down.
package aslt_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int NS_PER_US = 1000;

    // Link framing
    localparam int MF_CYCLES = 32;
    localparam int SYNC_WAIT_MF = 4;
    localparam int CGS_MIN_MF = 1;
    localparam int SYNC_WAIT_CYC = SYNC_WAIT_MF * MF_CYCLES;
    localparam int CGS_MIN_CYC = CGS_MIN_MF * MF_CYCLES;

    // Lane geometry
    localparam int NUM_CONV = 8;
    localparam int NUM_LANES = 4;
    localparam int OCT_MAX = 8;
    localparam int UI_FACTOR = 20;
    localparam int BITS_PER_CHAR = 10;
    localparam int WORD_BITS = 128;
    localparam int FIFO_DEPTH = 16;

    // Characters
    localparam logic [7:0] K28_5 = 8'hbc;
    localparam logic [7:0] K28_0 = 8'h1c;

    // Datapath latencies in sample cycles
    localparam int ADC_LAT = 16;
    localparam int RFD_LAT = 11;
    localparam int HPF_LAT = 100;

    // Speed modes
    localparam logic [1:0] SPD_MODE3 = 2'h2;
    localparam logic [1:0] SPD_MODE4 = 2'h3;

    // Trigger to start code, modes one to four (31/42/30/36, 31/33/30/30)
    localparam logic [7:0] TRIG_LAT_4L [4] = '{8'h1f, 8'h2a, 8'h1e, 8'h24};
    localparam logic [7:0] TRIG_LAT_2L [4] = '{8'h1f, 8'h21, 8'h1e, 8'h1e};

    // Wake-up times
    localparam int STBY_WAKE_US = 2;
    localparam int PDN_DEV_WAKE_US = 375;
    localparam int PDN_LINK_WAKE_US = 250;
    localparam int STBY_WAKE_CYC = STBY_WAKE_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int PDN_DEV_WAKE_CYC = PDN_DEV_WAKE_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int PDN_LINK_WAKE_CYC = PDN_LINK_WAKE_US * NS_PER_US / CLK_PERIOD_NS;

    // Synchroniser reset pattern: {standby, power_down, trigger, sync_n}
    localparam logic [3:0] PIN_INIT = 4'h1;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_IDLE = 5'h02,
        ST_WAIT = 5'h04,
        ST_CGS = 5'h08,
        ST_DATA = 5'h10
    } aslt_state_t;

    typedef struct packed {
        logic k;
        logic [7:0] d;
    } aslt_char_t;

    typedef aslt_char_t [NUM_LANES-1:0][OCT_MAX-1:0] aslt_lane_t;

    typedef struct packed {
        logic [1:0] speed;
        logic four_lane;
        logic rf_dec;
        logic hpf;
    } aslt_cfg_t;

    // RF decimator in use, forced on in the two fastest modes
    function automatic logic rf_on(aslt_cfg_t c);
        rf_on = c.rf_dec | (c.speed == SPD_MODE3) | (c.speed == SPD_MODE4);
    endfunction : rf_on

    function automatic logic [7:0] pipe_lat(aslt_cfg_t c);
        pipe_lat = 8'(ADC_LAT) + (rf_on(c) ? 8'(RFD_LAT) : 8'h00)
                 + (c.hpf ? 8'(HPF_LAT) : 8'h00);
    endfunction : pipe_lat

    function automatic logic [7:0] trig_lat(aslt_cfg_t c);
        trig_lat = c.four_lane ? TRIG_LAT_4L[c.speed] : TRIG_LAT_2L[c.speed];
    endfunction : trig_lat

    function automatic logic [7:0] ui_bits(aslt_cfg_t c);
        ui_bits = c.four_lane ? 8'(UI_FACTOR * NUM_CONV / 4) : 8'(UI_FACTOR * NUM_CONV / 2);
    endfunction : ui_bits

endpackage : aslt_pkg

// file: src/aslt_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes inputs are asynchronous pins; output changes once the
 * second and third stages agree.
 */
`timescale 1ns/10ps
`default_nettype none
module aslt_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Capture chain
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Accept a bit once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            q <= INIT;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    q[i] <= s3[i];
                end
            end
        end
    end
endmodule : aslt_sync
`default_nettype wire

// file: src/aslt_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; same clock on both sides.
 */
`timescale 1ns/10ps
`default_nettype none
module aslt_fifo #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Handshakes from the fill level
    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    // Storage write
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : aslt_fifo
`default_nettype wire

// file: src/aslt_link.sv
/*
 * Output-path timing of the converter device: wake-up from standby and
 * power-down, link start-up on the receiver's sync request, comma phase,
 * datapath latency before samples flow, and trigger to start code.
 * Assumes clk_sys is the 40 MHz sample clock, config is static while the
 * link runs, and samples arrive as one 128-bit word per sample cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module aslt_link import aslt_pkg::*; #(
    parameter int PDN_DEV_CYC = PDN_DEV_WAKE_CYC,
    parameter int PDN_LINK_CYC = PDN_LINK_WAKE_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire aslt_cfg_t cfg,
    input wire logic standby_pin,
    input wire logic power_down_pin,
    input wire logic transmit_trigger,
    input wire logic link_sync_request_n,
    input wire logic sample_valid,
    input wire logic [WORD_BITS-1:0] sample_data,
    output logic sample_ready,
    output aslt_lane_t serial_lane_out,
    output logic start_code,
    output logic link_up,
    output logic cgs_active,
    output logic device_ready,
    output logic rf_dec_active,
    output logic [7:0] pipe_latency,
    output logic [7:0] ui_bits_per_sample
);
    logic [3:0] pins_s;
    logic stby_s;
    logic pdn_s;
    logic trig_s;
    logic sync_s;
    logic trig_prev;
    logic sync_prev;
    logic trig_rise;
    logic sync_fall;
    logic [15:0] dev_wait;
    logic [15:0] link_wait;
    logic link_ready;
    aslt_state_t state;
    logic [7:0] st_cnt;
    logic [7:0] fill_cnt;
    logic drain;
    logic fifo_valid;
    logic [WORD_BITS-1:0] fifo_data;
    logic pop;
    logic [7:0] trig_cnt;
    aslt_lane_t next_lane;

    // Pin synchronisers
    aslt_sync #(
        .W(4),
        .INIT(PIN_INIT)
    ) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .d({standby_pin, power_down_pin, transmit_trigger, link_sync_request_n}),
        .q(pins_s)
    );

    assign stby_s = pins_s[3];
    assign pdn_s = pins_s[2];
    assign trig_s = pins_s[1];
    assign sync_s = pins_s[0];
    assign trig_rise = trig_s & ~trig_prev;
    assign sync_fall = ~sync_s & sync_prev;

    // Edge history
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            trig_prev <= 1'b0;
            sync_prev <= 1'b1;
        end else begin
            trig_prev <= trig_s;
            sync_prev <= sync_s;
        end
    end

    // Wake-up timers for device and link
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dev_wait <= 16'(PDN_DEV_CYC);
            link_wait <= 16'(PDN_LINK_CYC);
        end else if (pdn_s) begin
            dev_wait <= 16'(PDN_DEV_CYC);
            link_wait <= 16'(PDN_LINK_CYC);
        end else begin
            if (stby_s) begin
                dev_wait <= 16'(STBY_WAKE_CYC);
            end else if (dev_wait != 16'h0000) begin
                dev_wait <= dev_wait - 16'h0001;
            end
            if (link_wait != 16'h0000) begin
                link_wait <= link_wait - 16'h0001;
            end
        end
    end

    assign device_ready = (dev_wait == 16'h0000) & ~stby_s & ~pdn_s;
    assign link_ready = device_ready & (link_wait == 16'h0000);

    // Link start-up sequence
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state <= ST_OFF;
            st_cnt <= 8'h00;
        end else if (!link_ready) begin
            state <= ST_OFF;
            st_cnt <= 8'h00;
        end else begin
            case (state)
                ST_OFF: begin
                    state <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (!sync_s) begin
                        state <= ST_WAIT;
                        st_cnt <= 8'(SYNC_WAIT_CYC - 1);
                    end
                end
                ST_WAIT: begin
                    if (st_cnt == 8'h00) begin
                        state <= ST_CGS;
                        st_cnt <= 8'(CGS_MIN_CYC - 1);
                    end else begin
                        st_cnt <= st_cnt - 8'h01;
                    end
                end
                ST_CGS: begin
                    if (st_cnt != 8'h00) begin
                        st_cnt <= st_cnt - 8'h01;
                    end else if (sync_s) begin
                        state <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (sync_fall) begin
                        state <= ST_WAIT;
                        st_cnt <= 8'(SYNC_WAIT_CYC - 1);
                    end
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end

    assign link_up = state == ST_DATA;

    // Pipeline fill: samples flow only after the datapath latency
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fill_cnt <= 8'h00;
        end else if (state != ST_DATA) begin
            fill_cnt <= pipe_lat(cfg);
        end else if (fill_cnt != 8'h00) begin
            fill_cnt <= fill_cnt - 8'h01;
        end
    end

    assign drain = (state == ST_DATA) & (fill_cnt == 8'h00);
    assign pop = drain & fifo_valid;

    // Sample buffer with back-pressure to the source
    aslt_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out_valid(fifo_valid),
        .out_ready(drain),
        .out_data(fifo_data)
    );

    // Trigger to start code countdown
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            trig_cnt <= 8'h00;
            start_code <= 1'b0;
        end else begin
            if (trig_rise) begin
                trig_cnt <= trig_lat(cfg) - 8'h01;
            end else if (trig_cnt != 8'h00) begin
                trig_cnt <= trig_cnt - 8'h01;
            end
            start_code <= trig_cnt == 8'h01;
        end
    end

    // Lane characters: commas, sample octets, start code on lane 0
    always_comb begin
        next_lane = '0;
        for (int l = 0; l < NUM_LANES; l++) begin
            for (int j = 0; j < OCT_MAX; j++) begin
                if (state == ST_CGS) begin
                    next_lane[l][j] = '{k: 1'b1, d: K28_5};
                end else if (pop && (8'(j * BITS_PER_CHAR) < ui_bits(cfg))) begin
                    next_lane[l][j] = '{k: 1'b0, d: fifo_data[WORD_BITS-1-8*
                        (l * 32'(ui_bits(cfg)) / BITS_PER_CHAR + j) % WORD_BITS -: 8]};
                end
            end
        end
        if (trig_cnt == 8'h01) begin
            next_lane[0][0] = '{k: 1'b1, d: K28_0};
        end
    end

    // Registered lane outputs and comma flag
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            serial_lane_out <= '0;
            cgs_active <= 1'b0;
        end else begin
            serial_lane_out <= next_lane;
            cgs_active <= state == ST_CGS;
        end
    end

    // Configuration readback
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rf_dec_active <= 1'b0;
            pipe_latency <= 8'(ADC_LAT);
            ui_bits_per_sample <= 8'(UI_FACTOR * NUM_CONV / 2);
        end else begin
            rf_dec_active <= rf_on(cfg);
            pipe_latency <= pipe_lat(cfg);
            ui_bits_per_sample <= ui_bits(cfg);
        end
    end

    // Helper counters for checks
    logic [7:0] wait_len;
    logic [7:0] cgs_len;
    logic [7:0] data_age;
    logic [7:0] trig_age;
    logic [15:0] dark_len;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wait_len <= 8'h00;
            cgs_len <= 8'h00;
            data_age <= 8'h00;
            trig_age <= 8'h00;
            dark_len <= 16'h0000;
        end else begin
            wait_len <= (state == ST_WAIT) ? wait_len + 8'h01 : 8'h00;
            cgs_len <= (state == ST_CGS) ? cgs_len + 8'h01 : 8'h00;
            data_age <= (state == ST_DATA && data_age != 8'hff) ? data_age + 8'h01 : 8'h00;
            trig_age <= trig_rise ? 8'h01 : (trig_age != 8'hff ? trig_age + 8'h01 : trig_age);
            dark_len <= device_ready ? 16'h0000 :
                        (dark_len != 16'hffff ? dark_len + 16'h0001 : dark_len);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    rf_mode3_a: assert property (cfg.speed == SPD_MODE3 |=> rf_dec_active)
        else $error("mode three without RF decimator");
    rf_mode4_a: assert property ((cfg.speed == SPD_MODE4) && $stable(cfg) |=>
        pipe_latency >= 8'(ADC_LAT + RFD_LAT))
        else $error("mode four latency lacks RF decimator");
    sync_wait_a: assert property (state == ST_CGS && $past(state) == ST_WAIT |->
        wait_len == 8'(SYNC_WAIT_CYC))
        else $error("comma started before four multiframes");
    cgs_len_a: assert property (state == ST_DATA && $past(state) == ST_CGS |->
        cgs_len >= 8'(CGS_MIN_CYC))
        else $error("comma phase shorter than one multiframe");
    cgs_char_a: assert property (state == ST_CGS && trig_cnt != 8'h01 |=>
        cgs_active && serial_lane_out[NUM_LANES-1][0] == aslt_char_t'{k: 1'b1, d: K28_5})
        else $error("comma phase lane not sending K28.5");
    ui_bits_a: assert property ($stable(cfg) |=>
        16'(ui_bits_per_sample) * ($past(cfg.four_lane) ? 16'h0004 : 16'h0002)
        == 16'(UI_FACTOR * NUM_CONV))
        else $error("lane bit count per sample wrong");
    fill_lat_a: assert property ($rose(drain) |-> data_age == pipe_latency)
        else $error("samples flowed before datapath latency");
    trig_lat_a: assert property ($rose(start_code) |-> trig_age == trig_lat(cfg))
        else $error("start code latency wrong");
    // Dark time is at least the shorter of the standby and power-down waits
    wake_a: assert property ($rose(device_ready) |->
        dark_len >= 16'(STBY_WAKE_CYC < PDN_DEV_CYC ? STBY_WAKE_CYC : PDN_DEV_CYC))
        else $error("device woke too early");

endmodule : aslt_link
`default_nettype wire

// file: sim/aslt_rx_model.sv
/*
 * Behavioural model of the serial link receiver in logic.
 * Assumes go is raised by the bench once the device is ready.
 */
`timescale 1ns/10ps
`default_nettype none
module aslt_rx_model import aslt_pkg::*; (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic go,
    input wire aslt_lane_t serial_lane_out,
    output logic link_sync_request_n
);
    logic [2:0] seen;
    logic all_comma;

    // Every lane shows the comma on its first character
    always_comb begin
        all_comma = 1'b1;
        for (int l = 0; l < NUM_LANES; l++) begin
            if (serial_lane_out[l][0] !== {1'b1, K28_5}) begin
                all_comma = 1'b0;
            end
        end
    end

    // Request low until commas held four cycles, then released for good
    always_ff @(posedge clk_sys) begin
        if (!nrst || !go) begin
            seen <= 3'h0;
            link_sync_request_n <= 1'b1;
        end else if (seen == 3'h4) begin
            link_sync_request_n <= 1'b1;
        end else begin
            link_sync_request_n <= 1'b0;
            seen <= all_comma ? seen + 3'h1 : 3'h0;
        end
    end
endmodule : aslt_rx_model
`default_nettype wire

// file: sim/testbench.sv
/*
 * Self-checking bench for the link timing block and its receiver model.
 * Assumes short power-down counts of 20 and 10 cycles.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module testbench import aslt_pkg::*;;
    logic clk_sys, nrst, standby_pin, power_down_pin, transmit_trigger;
    logic sample_valid, sample_ready, start_code, link_up, cgs_active;
    logic device_ready, rf_dec_active, rx_go, sync_n;
    logic [WORD_BITS-1:0] sample_data;
    logic [7:0] pipe_latency, ui_bits_per_sample;
    aslt_cfg_t cfg;
    aslt_lane_t lanes;
    int fails = 0;
    int checked = 0;

    aslt_link #(.PDN_DEV_CYC(20), .PDN_LINK_CYC(10)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
        .cfg(cfg), .standby_pin(standby_pin), .power_down_pin(power_down_pin),
        .transmit_trigger(transmit_trigger), .link_sync_request_n(sync_n),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .sample_ready(sample_ready), .serial_lane_out(lanes), .start_code(start_code),
        .link_up(link_up), .cgs_active(cgs_active), .device_ready(device_ready),
        .rf_dec_active(rf_dec_active), .pipe_latency(pipe_latency),
        .ui_bits_per_sample(ui_bits_per_sample));

    aslt_rx_model i_rx (.clk_sys(clk_sys), .nrst(nrst), .go(rx_go),
        .serial_lane_out(lanes), .link_sync_request_n(sync_n));

    // Clock of 25 ns
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // One edge, then let its updates land
    task automatic cyc();
        @(posedge clk_sys);
        #1;
    endtask : cyc

    // Bounded wait for a level; n counts the edges taken
    task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v) begin
            cyc();
            n++;
            if (n > lim) begin
                `CHK(1'b0, 1'b1, "wait timed out")
                stop_test();
            end
        end
    endtask : wait_lvl

    function automatic logic [WORD_BITS-1:0] word(int w);
        for (int m = 0; m < 16; m++) begin
            word[127-8*m -: 8] = {w[3:0], m[3:0]} ^ 8'h80;
        end
    endfunction : word

    // Four-lane layout: lane l char j holds octet 4l+j, upper chars empty
    function automatic aslt_lane_t exp_lane(int w);
        logic [3:0] m;
        exp_lane = '0;
        for (int l = 0; l < 4; l++) begin
            for (int j = 0; j < 4; j++) begin
                m = 4'(l * 4 + j);
                exp_lane[l][j] = {1'b0, {w[3:0], m} ^ 8'h80};
            end
        end
    endfunction : exp_lane

    task automatic t_wake();
        int n;
        `CHK(device_ready, 1'b0, "ready in reset")
        @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        wait_lvl(device_ready, 1'b1, 60, n);
        `CHK(n inside {[19:26]}, 1'b1, "power-down wake time")
        @(posedge clk_sys);
        standby_pin <= 1'b1;
        #1;
        wait_lvl(device_ready, 1'b0, 20, n);
        @(posedge clk_sys);
        standby_pin <= 1'b0;
        #1;
        wait_lvl(device_ready, 1'b1, 120, n);
        `CHK(n inside {[80:86]}, 1'b1, "standby wake time")
    endtask : t_wake

    task automatic t_cfg();
        logic rf;
        for (int k = 0; k < 32; k++) begin
            @(posedge clk_sys);
            cfg <= 5'(k);
            repeat (3) cyc();
            rf = cfg.rf_dec | (cfg.speed >= 2'h2);
            `CHK(rf_dec_active, rf, "decimator use")
            `CHK(pipe_latency, 8'(16 + 11 * rf + 100 * cfg.hpf), "latency")
            `CHK(ui_bits_per_sample, cfg.four_lane ? 8'h28 : 8'h50, "lane bits")
        end
    endtask : t_cfg

    task automatic t_fill();
        @(posedge clk_sys);
        cfg <= '{speed: 2'h0, four_lane: 1'b1, rf_dec: 1'b0, hpf: 1'b0};
        for (int w = 0; w < 17; w++) begin
            @(posedge clk_sys);
            sample_valid <= 1'b1;
            sample_data <= word(w);
            #1;
            `CHK(sample_ready, 1'(w < 16), "fifo ready")
        end
        repeat (3) cyc();
        `CHK(sample_ready, 1'b0, "fifo stays full")
        @(posedge clk_sys);
        sample_valid <= 1'b0;
    endtask : t_fill

    task automatic t_link();
        int n;
        logic ok;
        @(posedge clk_sys);
        rx_go <= 1'b1;
        #1;
        wait_lvl(sync_n, 1'b0, 10, n);
        wait_lvl(cgs_active, 1'b1, 200, n);
        `CHK(n inside {[130:138]}, 1'b1, "sync to comma delay")
        ok = 1'b1;
        for (int l = 0; l < 4; l++) begin
            for (int j = 0; j < 8; j++) begin
                ok &= (lanes[l][j] === {1'b1, K28_5});
            end
        end
        `CHK(ok, 1'b1, "comma on all lanes")
        wait_lvl(cgs_active, 1'b0, 100, n);
        `CHK(n inside {[32:45]}, 1'b1, "comma duration")
        `CHK(link_up, 1'b1, "link up after release")
        `CHK(lanes[0][0].k, 1'b0, "commas stopped")
        n = 0;
        while (lanes === '0 && n < 60) begin
            cyc();
            n++;
        end
        `CHK(n inside {[15:17]}, 1'b1, "data after pipeline")
        for (int w = 0; w < 16; w++) begin
            `CHK(lanes, exp_lane(w), "lane word")
            cyc();
        end
        `CHK(lanes, aslt_lane_t'('0), "lanes idle when empty")
    endtask : t_link

    task automatic t_trig();
        int n;
        int off0;
        int lat;
        int tab4 [4] = '{31, 42, 30, 36};
        int tab2 [4] = '{31, 33, 30, 30};
        off0 = -1;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys);
            cfg <= '{speed: 2'(k / 2), four_lane: 1'(k % 2), rf_dec: 1'b0, hpf: 1'b0};
            repeat (8) cyc();
            lat = (k % 2) ? tab4[k/2] : tab2[k/2];
            @(posedge clk_sys);
            transmit_trigger <= 1'b1;
            #1;
            wait_lvl(start_code, 1'b1, 80, n);
            `CHK(lanes[0][0], {1'b1, K28_0}, "start character")
            if (off0 < 0) begin
                off0 = n - lat;
                `CHK(off0 inside {[2:6]}, 1'b1, "trigger delay")
            end
            `CHK(n - lat, off0, "trigger to start code")
            @(posedge clk_sys);
            transmit_trigger <= 1'b0;
            #1;
            `CHK(start_code, 1'b0, "start code one cycle")
        end
    endtask : t_trig

    // Two-lane layout: lane l char j holds octet 8l+j of one word
    task automatic t_two();
        @(posedge clk_sys);
        cfg <= '{speed: 2'h0, four_lane: 1'b0, rf_dec: 1'b0, hpf: 1'b0};
        sample_valid <= 1'b1;
        sample_data <= word(5);
        @(posedge clk_sys);
        sample_valid <= 1'b0;
        cyc();
        for (int l = 0; l < 2; l++) begin
            for (int j = 0; j < 8; j++) begin
                `CHK(lanes[l][j], {1'b0, {4'h5, 4'(l * 8 + j)} ^ 8'h80}, "two-lane octet")
            end
        end
    endtask : t_two

    // Main sequence
    initial begin
        nrst = 1'b0;
        cfg = '0;
        standby_pin = 1'b0;
        power_down_pin = 1'b0;
        transmit_trigger = 1'b0;
        sample_valid = 1'b0;
        sample_data = '0;
        rx_go = 1'b0;
        repeat (4) @(posedge clk_sys);
        t_wake();
        t_cfg();
        t_fill();
        t_link();
        t_trig();
        t_two();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
